/* hw/vtcf_top.sv */
/*
  VLAN tag classify and filter: takes byte frames with their ingress port
  and forwarding mask, classifies by tag or port default, filters by VLAN
  membership, inserts or strips the tag and rebuilds the frame check.
  Assumes frames carry their check sequence, forwarding lookup is on the
  same clock, and software uses the Avalon-MM register slave.
*/
// Contract
// - Insert four tag octets right after source MAC, before original type field.
// - Frame is tagged exactly when type field at tag position is 0x8100.
// - Tag control is priority 3 bits, CFI 1 bit, VID 12 bits.
// - Insertion adds exactly four octets, original bytes unchanged.
// - Inserting a tag recomputes the frame check over the new frame.
// - Untagged frames take the receiving port default VID for forwarding.
// - Tagged frames forward by their own VID, port default ignored.
// - One default VID per port, resetting to 1.
// - Ports join many VLANs, limited by membership table size.
// - Drop toward a transmit port that is not in the frame VLAN.
// - Port-based mode drops when receive and transmit default VIDs differ.
// - Each port selects tagging or untagging behaviour.
// - Tagging port tags untagged frames, leaves tagged ones untouched.
// - Untagging port strips tags, leaves untagged frames untouched.
// - Per-port ingress filter enable makes tag inspection decide forwarding.
// - Filtering drops tagged frames whose receive port lacks that VLAN.
// - Tagged frames passing that check still need destination membership.
// - Untagged frames use port default VID, need destination in same VLAN.
// - Floods reach only member ports of the frame VLAN.
// - VID 4095 is refused in the table; initial VLAN is VID 1.
`timescale 1ns/1ns
`default_nettype none
module vtcf_top #(
  parameter int NUM_PORTS = 4,
  parameter int NUM_VLANS = 16
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire vtcf_pkg::vtcf_beat_s RX_BEAT,
  input wire logic RX_VALID,
  output logic RX_READY,
  input wire logic [3:0] RX_PORT,
  input wire logic [NUM_PORTS-1:0] DST_MASK,
  output vtcf_pkg::vtcf_beat_s TX_BEAT,
  output logic TX_VALID,
  input wire logic TX_READY,
  output vtcf_pkg::vtcf_info_s TX_INFO,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);
  import vtcf_pkg::*;

  localparam int NP = NUM_PORTS;
  localparam int NV = NUM_VLANS;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave: one wait cycle, then the access completes
  logic ack_q;
  logic [31:0] rdata_q;
  logic port_based_q;
  logic rej_q;
  logic [31:0] fwd_cnt_q;
  logic [31:0] drop_cnt_q;
  logic [11:0] pvid_q [NP];
  logic [2:0] prio_q [NP];
  logic [1:0] mode_q [NP];
  logic filt_q [NP];
  logic [11:0] tvid_q [NV];
  logic [NP-1:0] tmem_q [NV];
  logic tval_q [NV];

  wire bus_req = AVS_READ | AVS_WRITE;
  wire bus_do_wr = AVS_WRITE & ack_q;
  wire [3:0] sub = AVS_ADDRESS[3:0];
  wire is_port = (AVS_ADDRESS[7:4] == VTCF_A_PORT_BASE[7:4]) && (32'(sub) < NP);
  wire is_vlan = (AVS_ADDRESS[7:4] == VTCF_A_VLAN_BASE[7:4]) && (32'(sub) < NV);
  wire [11:0] wr_vid = AVS_WRITEDATA[VTCF_F_VID +: 12];
  // Reserved identifier never enters the table as a live VLAN
  wire vid_bad = AVS_WRITEDATA[VTCF_F_VALID] && (wr_vid == VTCF_VID_RESERVED);
  wire vlan_wr_ok = bus_do_wr && is_vlan && !vid_bad;
  wire vlan_wr_bad = bus_do_wr && is_vlan && vid_bad;

  wire [31:0] port_word = is_port ? ({13'h0000, filt_q[sub[$clog2(NP)-1:0]], mode_q[sub[$clog2(NP)-1:0]],
      1'b0, prio_q[sub[$clog2(NP)-1:0]], pvid_q[sub[$clog2(NP)-1:0]]}) : 32'h0000_0000;
  wire [31:0] vlan_word = is_vlan ? ({tval_q[sub[$clog2(NV)-1:0]], 15'(tmem_q[sub[$clog2(NV)-1:0]]),
      4'h0, tvid_q[sub[$clog2(NV)-1:0]]}) : 32'h0000_0000;
  // Unmapped addresses read as zero and swallow writes
  wire [31:0] rd_mux =
      (AVS_ADDRESS == VTCF_A_CTRL) ? {31'h0000_0000, port_based_q} :
      (AVS_ADDRESS == VTCF_A_STAT) ? {31'h0000_0000, rej_q} :
      (AVS_ADDRESS == VTCF_A_FWD_CNT) ? fwd_cnt_q :
      (AVS_ADDRESS == VTCF_A_DROP_CNT) ? drop_cnt_q :
      (port_word | vlan_word);

  assign AVS_WAITREQUEST = bus_req & ~ack_q;
  assign AVS_READDATA = rdata_q;

  // Handshake and read capture
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (AVS_READ && !ack_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Global control and refusal flag; good table write clears the flag
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      port_based_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      if (bus_do_wr && AVS_ADDRESS == VTCF_A_CTRL) begin
        port_based_q <= AVS_WRITEDATA[0];
      end
      if (vlan_wr_bad) begin
        rej_q <= 1'b1;
      end else if (vlan_wr_ok) begin
        rej_q <= 1'b0;
      end
    end
  end

  // Per-port settings: default VID 1 on every port
  for (genvar p = 0; p < NP; p++) begin : g_port
    always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
        pvid_q[p] <= VTCF_VID_DEFAULT;
        prio_q[p] <= VTCF_PRIO_RST;
        mode_q[p] <= VTCF_MODE_PASS;
        filt_q[p] <= 1'b0;
      end else if (bus_do_wr && is_port && 32'(sub) == p) begin
        pvid_q[p] <= AVS_WRITEDATA[VTCF_F_PVID +: 12];
        prio_q[p] <= AVS_WRITEDATA[VTCF_F_PRIO +: 3];
        mode_q[p] <= AVS_WRITEDATA[VTCF_F_MODE +: 2];
        filt_q[p] <= AVS_WRITEDATA[VTCF_F_FILT];
      end
    end
  end

  // Membership table; entry 0 starts as the initial VLAN with every port
  for (genvar v = 0; v < NV; v++) begin : g_vlan
    always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
        tvid_q[v] <= (v == 0) ? VTCF_VID_DEFAULT : 12'h000;
        tmem_q[v] <= (v == 0) ? {NP{1'b1}} : {NP{1'b0}};
        tval_q[v] <= (v == 0);
      end else if (vlan_wr_ok && 32'(sub) == v) begin
        tvid_q[v] <= wr_vid;
        tmem_q[v] <= AVS_WRITEDATA[VTCF_F_MEMB +: NP];
        tval_q[v] <= AVS_WRITEDATA[VTCF_F_VALID];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame path state
  vtcf_state_e st_q;
  logic [7:0] hdr_q [VTCF_HDR_LEN];
  logic [4:0] cnt_q;
  logic [1:0] ring_q;
  logic [1:0] fcs_q;
  logic [3:0] in_port_q;
  logic [NP-1:0] dst_q;
  logic ins_q;
  logic strip_q;
  vtcf_beat_s tx_q;
  logic tx_vld_q;
  vtcf_info_s info_q;
  logic [31:0] crc;

  wire adv = ~tx_vld_q | TX_READY;
  wire rx_take = RX_VALID & RX_READY;
  wire [$clog2(NP)-1:0] ip = in_port_q[$clog2(NP)-1:0];

  assign RX_READY = (st_q == VTCF_S_HDR) || (st_q == VTCF_S_DROP) || (st_q == VTCF_S_BODY && adv);

  ////////////////////////////////////////////////////////////////////////////
  // Classification from the held header
  wire rx_tagged = {hdr_q[VTCF_TPID_POS], hdr_q[VTCF_TPID_POS+1]} == VTCF_TPID;
  wire [15:0] rx_tci = {hdr_q[VTCF_TPID_POS+2], hdr_q[VTCF_TPID_POS+3]};
  // Tag VID wins for tagged frames; port default only for untagged ones
  wire [11:0] cls_vid = rx_tagged ? rx_tci[11:0] : pvid_q[ip];
  wire [2:0] cls_prio = rx_tagged ? rx_tci[15:13] : prio_q[ip];
  wire cls_cfi = rx_tagged & rx_tci[12];

  // Membership of the classified VLAN, OR over matching entries
  logic [NP-1:0] memb_acc [NV+1];
  assign memb_acc[0] = {NP{1'b0}};
  for (genvar v = 0; v < NV; v++) begin : g_look
    assign memb_acc[v+1] = memb_acc[v] | ((tval_q[v] && tvid_q[v] == cls_vid) ? tmem_q[v] : {NP{1'b0}});
  end
  wire [NP-1:0] memb = memb_acc[NV];

  // Ports sharing the receiving port default VID
  logic [NP-1:0] same_pvid;
  for (genvar p = 0; p < NP; p++) begin : g_pb
    assign same_pvid[p] = pvid_q[p] == pvid_q[ip];
  end

  // Destinations and floods limited to VLAN members
  wire [NP-1:0] pb_gate = port_based_q ? same_pvid : {NP{1'b1}};
  wire [NP-1:0] fwd_mask = dst_q & memb & pb_gate;
  wire ingress_fail = filt_q[ip] & rx_tagged & ~memb[ip];
  wire frame_drop = ingress_fail | (fwd_mask == {NP{1'b0}});
  wire do_ins = (mode_q[ip] == VTCF_MODE_TAG) & ~rx_tagged;
  wire do_strip = (mode_q[ip] == VTCF_MODE_UNTAG) & rx_tagged;

  ////////////////////////////////////////////////////////////////////////////
  // Header emission: MAC pair, then optional tag, then rest of header
  wire [15:0] ins_tci = {info_q.prio, 1'b0, info_q.vid};
  wire in_tag_slot = ins_q && (cnt_q >= 5'd12) && (cnt_q < 5'd16);
  wire [4:0] hdr_idx = (ins_q && cnt_q >= 5'd16) ? 5'(cnt_q - 5'd4) : cnt_q;
  wire [7:0] tag_byte =
      (cnt_q[1:0] == 2'd0) ? VTCF_TPID[15:8] :
      (cnt_q[1:0] == 2'd1) ? VTCF_TPID[7:0] :
      (cnt_q[1:0] == 2'd2) ? ins_tci[15:8] : ins_tci[7:0];
  wire [7:0] head_byte = in_tag_slot ? tag_byte : hdr_q[hdr_idx];
  // Stripping ends the header at the source MAC, skipping the four tag octets
  wire [4:0] head_end = ins_q ? 5'd19 : (strip_q ? 5'd11 : 5'd15);
  wire head_last = cnt_q == head_end;
  wire [4:0] ring_idx = 5'(5'd16 + {3'b000, ring_q});
  wire [7:0] fcs_byte = ~crc[{fcs_q, 3'b000} +: 8];

  // Check accumulates every header and body byte sent, so it covers the modified frame
  wire crc_en = adv && ((st_q == VTCF_S_HEAD) || (st_q == VTCF_S_BODY && RX_VALID));
  wire [7:0] crc_byte = (st_q == VTCF_S_HEAD) ? head_byte : hdr_q[ring_idx];

  vtcf_crc u_crc (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .clr(st_q == VTCF_S_DEC),
    .en(crc_en),
    .data(crc_byte),
    .crc(crc)
  );

  // Header store and ring: incoming byte replaces the oldest held one
  always_ff @(posedge CLK_SYS) begin
    if (rx_take && st_q == VTCF_S_HDR) begin
      hdr_q[RX_BEAT.sop ? 5'd0 : cnt_q] <= RX_BEAT.data;
    end else if (rx_take && st_q == VTCF_S_BODY) begin
      hdr_q[ring_idx] <= RX_BEAT.data;
    end
  end

  // Frame sequencer
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_q <= VTCF_S_HDR;
      cnt_q <= 5'd0;
      ring_q <= 2'd0;
      fcs_q <= 2'd0;
      in_port_q <= 4'h0;
      dst_q <= {NP{1'b0}};
      ins_q <= 1'b0;
      strip_q <= 1'b0;
      info_q <= '0;
      fwd_cnt_q <= 32'h0000_0000;
      drop_cnt_q <= 32'h0000_0000;
    end else begin
      unique case (st_q)
        VTCF_S_HDR: begin
          if (rx_take) begin
            if (RX_BEAT.sop) begin
              in_port_q <= RX_PORT;
              dst_q <= DST_MASK;
            end
            // Runts too short to hold a header and check are dropped
            if (RX_BEAT.eop) begin
              cnt_q <= 5'd0;
              drop_cnt_q <= drop_cnt_q + 32'd1;
            end else if ((RX_BEAT.sop ? 5'd0 : cnt_q) == 5'(VTCF_HDR_LEN - 1)) begin
              st_q <= VTCF_S_DEC;
            end else begin
              cnt_q <= 5'((RX_BEAT.sop ? 5'd0 : cnt_q) + 5'd1);
            end
          end
        end
        VTCF_S_DEC: begin
          cnt_q <= 5'd0;
          ring_q <= 2'd0;
          fcs_q <= 2'd0;
          ins_q <= do_ins;
          strip_q <= do_strip;
          info_q <= '{port_mask: 16'(fwd_mask), vid: cls_vid, prio: cls_prio, cfi: cls_cfi,
                      rx_tagged: rx_tagged, tx_tagged: (rx_tagged & ~do_strip) | do_ins};
          if (frame_drop) begin
            st_q <= VTCF_S_DROP;
            drop_cnt_q <= drop_cnt_q + 32'd1;
          end else begin
            st_q <= VTCF_S_HEAD;
          end
        end
        VTCF_S_HEAD: begin
          if (adv) begin
            cnt_q <= 5'(cnt_q + 5'd1);
            if (head_last) begin
              st_q <= VTCF_S_BODY;
            end
          end
        end
        VTCF_S_BODY: begin
          // Old check bytes stay in the ring and are discarded at the end
          if (rx_take) begin
            ring_q <= 2'(ring_q + 2'd1);
            if (RX_BEAT.eop) begin
              st_q <= VTCF_S_FCS;
            end
          end
        end
        VTCF_S_FCS: begin
          if (adv) begin
            fcs_q <= 2'(fcs_q + 2'd1);
            if (fcs_q == 2'd3) begin
              st_q <= VTCF_S_HDR;
              cnt_q <= 5'd0;
              fwd_cnt_q <= fwd_cnt_q + 32'd1;
            end
          end
        end
        VTCF_S_DROP: begin
          if (rx_take && RX_BEAT.eop) begin
            st_q <= VTCF_S_HDR;
            cnt_q <= 5'd0;
          end
        end
      endcase
    end
  end

  // Output register; a stalled sink freezes it and, while the body streams, the input
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      tx_q <= '0;
      tx_vld_q <= 1'b0;
    end else if (adv) begin
      tx_vld_q <= 1'b0;
      if (st_q == VTCF_S_HEAD) begin
        tx_q <= '{data: head_byte, sop: cnt_q == 5'd0, eop: 1'b0};
        tx_vld_q <= 1'b1;
      end else if (st_q == VTCF_S_BODY && RX_VALID) begin
        tx_q <= '{data: hdr_q[ring_idx], sop: 1'b0, eop: 1'b0};
        tx_vld_q <= 1'b1;
      end else if (st_q == VTCF_S_FCS) begin
        tx_q <= '{data: fcs_byte, sop: 1'b0, eop: fcs_q == 2'd3};
        tx_vld_q <= 1'b1;
      end
    end
  end

  assign TX_BEAT = tx_q;
  assign TX_VALID = tx_vld_q;
  assign TX_INFO = info_q;

endmodule
`default_nettype wire

/* hw/vtcf_pkg.sv */
/*
  Shared constants, types and register map of the VLAN tag classify and
  filter block. Assumes a single switch clock and byte-wide frame streams.
*/
package vtcf_pkg;

  // Frame format
  localparam logic [15:0] VTCF_TPID = 16'h8100;
  localparam int VTCF_TAG_LEN = 4;
  localparam int VTCF_TPID_POS = 12;
  localparam int VTCF_HDR_LEN = 20;
  localparam logic [31:0] VTCF_CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] VTCF_CRC_POLY = 32'hEDB8_8320;

  // Identifiers
  localparam logic [11:0] VTCF_VID_DEFAULT = 12'h001;
  localparam logic [11:0] VTCF_VID_RESERVED = 12'hFFF;

  // Register word addresses
  localparam logic [7:0] VTCF_A_CTRL = 8'h00;
  localparam logic [7:0] VTCF_A_STAT = 8'h01;
  localparam logic [7:0] VTCF_A_FWD_CNT = 8'h02;
  localparam logic [7:0] VTCF_A_DROP_CNT = 8'h03;
  localparam logic [7:0] VTCF_A_PORT_BASE = 8'h10;
  localparam logic [7:0] VTCF_A_VLAN_BASE = 8'h20;

  // Port configuration fields
  localparam int VTCF_F_PVID = 0;
  localparam int VTCF_F_PRIO = 12;
  localparam int VTCF_F_MODE = 16;
  localparam int VTCF_F_FILT = 18;
  // VLAN entry fields
  localparam int VTCF_F_VID = 0;
  localparam int VTCF_F_MEMB = 16;
  localparam int VTCF_F_VALID = 31;

  // Port tag modes and reset priority
  localparam logic [1:0] VTCF_MODE_PASS = 2'h0;
  localparam logic [1:0] VTCF_MODE_TAG = 2'h1;
  localparam logic [1:0] VTCF_MODE_UNTAG = 2'h2;
  localparam logic [2:0] VTCF_PRIO_RST = 3'h0;

  typedef enum logic [5:0] {
    VTCF_S_HDR = 6'b00_0001,
    VTCF_S_DEC = 6'b00_0010,
    VTCF_S_HEAD = 6'b00_0100,
    VTCF_S_BODY = 6'b00_1000,
    VTCF_S_FCS = 6'b01_0000,
    VTCF_S_DROP = 6'b10_0000
  } vtcf_state_e;

  // One stream byte
  typedef struct packed {
    logic [7:0] data;
    logic sop;
    logic eop;
  } vtcf_beat_s;

  // Classification result per frame
  typedef struct packed {
    logic [15:0] port_mask;
    logic [11:0] vid;
    logic [2:0] prio;
    logic cfi;
    logic rx_tagged;
    logic tx_tagged;
  } vtcf_info_s;

endpackage

/* hw/vtcf_crc.sv */
/*
  Byte-serial Ethernet frame check sequence generator, reflected form.
  Assumes the caller clears it before a frame and feeds bytes in wire order.
*/
`timescale 1ns/1ns
`default_nettype none
module vtcf_crc (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [31:0] crc
);
  import vtcf_pkg::*;

  logic [31:0] crc_q;
  logic [31:0] crc_d;

  ////////////////////////////////////////////////////////////////////////////
  // Eight shift steps per byte, least significant bit first
  always_comb begin
    crc_d = crc_q;
    for (int i = 0; i < 8; i++) begin
      if (crc_d[0] ^ data[i]) begin
        crc_d = (crc_d >> 1) ^ VTCF_CRC_POLY;
      end else begin
        crc_d = crc_d >> 1;
      end
    end
  end

  // Clear wins over update so a new frame never inherits old state
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      crc_q <= VTCF_CRC_INIT;
    end else if (en) begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;

endmodule
`default_nettype wire

/* tb/vtcf_properties.sv */
/*
  Port checker for vtcf_top, attached by bind.
  Assumes the bench keeps one frame in flight at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module vtcf_props
  import vtcf_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire vtcf_pkg::vtcf_beat_s RX_BEAT,
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire vtcf_pkg::vtcf_beat_s TX_BEAT,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire vtcf_pkg::vtcf_info_s TX_INFO,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  // Egress beat position and ingress frame length
  logic [15:0] pos_q;
  logic [15:0] in_q;
  logic [15:0] len_q;
  wire tx_go = TX_VALID & TX_READY;
  wire rx_go = RX_VALID & RX_READY;
  wire [15:0] idx = TX_BEAT.sop ? 16'h0000 : pos_q;
  wire [15:0] in_d = RX_BEAT.sop ? 16'h0001 : in_q + 16'h0001;
  wire ins = TX_INFO.tx_tagged & !TX_INFO.rx_tagged;
  wire del = TX_INFO.rx_tagged & !TX_INFO.tx_tagged;
  // Length latched at eop, since the next frame may start early
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      pos_q <= 16'h0000;
      in_q <= 16'h0000;
      len_q <= 16'h0000;
    end else begin
      if (tx_go) pos_q <= TX_BEAT.eop ? 16'h0000 : idx + 16'h0001;
      if (rx_go) in_q <= in_d;
      if (rx_go & RX_BEAT.eop) len_q <= in_d;
    end
  end
  ////////////////////////////////////////
  wait_one_a: assert property ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer not one cycle late");
  tx_hold_a: assert property (TX_VALID & !TX_READY |=> TX_VALID & $stable(TX_BEAT))
    else $error("egress beat moved while stalled");
  frame_mark_a: assert property (TX_VALID |-> TX_BEAT.sop == (pos_q == 16'h0000))
    else $error("egress start marker misplaced");
  tag_type_a: assert property (tx_go & TX_INFO.tx_tagged & idx == 16'h000c |-> TX_BEAT.data == 8'h81)
    else $error("tag type high byte wrong");
  tag_low_a: assert property (tx_go & TX_INFO.tx_tagged & idx == 16'h000d |-> TX_BEAT.data == 8'h00)
    else $error("tag type low byte wrong");
  tag_tci_a: assert property (tx_go & TX_INFO.tx_tagged & idx == 16'h000e
    |-> TX_BEAT.data == {TX_INFO.prio, TX_INFO.cfi, TX_INFO.vid[11:8]})
    else $error("tag control high byte wrong");
  tag_vid_a: assert property (tx_go & TX_INFO.tx_tagged & idx == 16'h000f |-> TX_BEAT.data == TX_INFO.vid[7:0])
    else $error("tag identifier low byte wrong");
  sop_mask_a: assert property (tx_go & TX_BEAT.sop |-> TX_INFO.port_mask != 16'h0000)
    else $error("frame sent with empty port mask");
  frame_len_a: assert property (tx_go & TX_BEAT.eop
    |-> idx + 16'h0001 + (del ? 16'h0004 : 16'h0000) == len_q + (ins ? 16'h0004 : 16'h0000))
    else $error("egress frame length wrong");
endmodule
bind vtcf_top vtcf_props u_props (.CLK_SYS, .RST_N, .RX_BEAT, .RX_VALID, .RX_READY, .TX_BEAT, .TX_VALID,
  .TX_READY, .TX_INFO, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST);
`default_nettype wire

/* tb/vtcf_sink.sv */
/*
  Egress sink standing for the port MAC side.
  Assumes the bench reads the beats off the design ports.
*/
`timescale 1ns/1ns
`default_nettype none
module vtcf_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  output logic ready
);
  logic [7:0] lfsr_q;
  // Slow mode stalls on a pseudo-random pattern
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lfsr_q <= 8'h5a;
      ready <= 1'b0;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      ready <= !slow | lfsr_q[0];
    end
  end
endmodule
`default_nettype wire

/* tb/vlan_tag_classify_filter_tb.sv */
/*
  Self-checking bench for vtcf_top.
  Assumes one frame in flight; sink model drives egress ready.
*/
`timescale 1ns/1ns
`default_nettype none
module vlan_tag_classify_filter_tb;
  import vtcf_pkg::*;
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin num_errors++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rxv = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic slow = 1'b0;
  logic rxr, txv, txr, wreq;
  logic [3:0] rxp = 4'h0;
  logic [3:0] dst = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, ed;
  logic [31:0] seed = 32'h6d85_a4b0;
  vtcf_beat_s rxb = '0;
  vtcf_beat_s txb, eb;
  vtcf_info_s info, ei;
  vtcf_beat_s eq[$];
  vtcf_info_s iq[$];
  logic [31:0] rq[$];
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int nfw = 0;
  int ndr = 0;
  always #5 clk = ~clk;
  vtcf_top #(.NUM_PORTS(4), .NUM_VLANS(16)) i_dut (.CLK_SYS(clk), .RST_N(rst_n), .RX_BEAT(rxb), .RX_VALID(rxv),
    .RX_READY(rxr), .RX_PORT(rxp), .DST_MASK(dst), .TX_BEAT(txb), .TX_VALID(txv), .TX_READY(txr), .TX_INFO(info),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq));
  vtcf_sink i_sink (.clk(clk), .rst_n(rst_n), .slow(slow), .ready(txr));
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Reflected check sequence, bit at a time for clarity over speed
  function automatic logic [31:0] crc(input logic [7:0] b[$]);
    logic [31:0] c;
    c = VTCF_CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {24'h00_0000, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ VTCF_CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  // Bus cycle held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    // Released only after the edge that saw waitrequest low
    do @(posedge clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // Send one frame; act 0 drop, 1 keep, 2 insert tag, 3 strip tag
  task automatic frame(input logic [3:0] p, input logic [3:0] m, input logic [3:0] pm, input logic [15:0] tci,
    input logic tg, input int len, input int act);
    logic [7:0] f[$];
    logic [7:0] o[$];
    logic [31:0] c;
    for (int i = 0; i < len; i++) f.push_back(8'(rnd()));
    if (tg) begin
      f[12] = 8'h81;
      f[13] = 8'h00;
      f[14] = tci[15:8];
      f[15] = tci[7:0];
    end else if (len > 12) f[12] = 8'h08;
    o = f;
    if (act == 2) o = {f[0:11], 8'h81, 8'h00, tci[15:8], tci[7:0], f[12:$]};
    if (act == 3) o = {f[0:11], f[16:$]};
    c = crc(f);
    for (int k = 0; k < 4; k++) f.push_back(c[8*k+:8]);
    c = crc(o);
    for (int k = 0; k < 4; k++) o.push_back(c[8*k+:8]);
    if (act != 0) begin
      foreach (o[i]) eq.push_back('{o[i], i == 0, i == o.size() - 1});
      iq.push_back('{{12'h000, pm}, tci[11:0], tci[15:13], tci[12], tg, act == 2 || (tg && act != 3)});
      nfw++;
    end else ndr++;
    @(posedge clk);
    rxp <= p;
    dst <= m;
    foreach (f[i]) begin
      rxv <= 1'b1;
      rxb <= '{f[i], i == 0, i == f.size() - 1};
      do @(posedge clk); while (rxr !== 1'b1);
    end
    rxv <= 1'b0;
    for (int k = 0; k < 500 && eq.size() > 0; k++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Compares read answers and egress beats against the notes
  // Read data taken at the very edge that completes the read
  always @(posedge clk) begin
    if (rd === 1'b1 && wreq === 1'b0) begin
      ed = rq.pop_front();
      `CHK("readdata", ed, rdat)
    end
  end
  // Egress beats looked at while they stand before the taking edge
  always @(negedge clk) begin
    if (txv === 1'b1 && txr === 1'b1) begin
      eb = eq.pop_front();
      `CHK("tx beat", eb, txb)
      if (eb.sop) begin
        ei = iq.pop_front();
        `CHK("tx info", ei, info)
      end
    end
  end
  // Cuts a hung run short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdx(VTCF_A_PORT_BASE, 32'h0000_0001);
    rdx(VTCF_A_VLAN_BASE, 32'h800f_0001);
    bus(1'b1, 8'hff, 32'h1234_5678);
    rdx(8'hff, 32'h0000_0000);
    bus(1'b1, VTCF_A_PORT_BASE + 8'h01, 32'h0001_5001);
    bus(1'b1, VTCF_A_PORT_BASE + 8'h02, 32'h0006_0001);
    rdx(VTCF_A_PORT_BASE + 8'h01, 32'h0001_5001);
    bus(1'b1, VTCF_A_VLAN_BASE + 8'h01, 32'h800f_0123);
    bus(1'b1, VTCF_A_VLAN_BASE + 8'h02, 32'h8001_0234);
    bus(1'b1, VTCF_A_VLAN_BASE + 8'h03, 32'h800f_0fff);
    rdx(VTCF_A_STAT, 32'h0000_0001);
    bus(1'b1, VTCF_A_VLAN_BASE + 8'h04, 32'h8009_0002);
    rdx(VTCF_A_STAT, 32'h0000_0000);
    frame(4'h0, 4'h2, 4'h2, 16'h0001, 1'b0, 64, 1);
    slow <= 1'b1;
    frame(4'h1, 4'h1, 4'h1, 16'ha001, 1'b0, 64, 2);
    frame(4'h1, 4'h1, 4'h1, 16'h7123, 1'b1, 64, 1);
    frame(4'h2, 4'h1, 4'h1, 16'h7123, 1'b1, 64, 3);
    frame(4'h2, 4'h1, 4'h1, 16'h0001, 1'b0, 64, 1);
    frame(4'h2, 4'h1, 4'h0, 16'h0234, 1'b1, 64, 0);
    frame(4'h0, 4'h8, 4'h0, 16'h0234, 1'b1, 64, 0);
    frame(4'h0, 4'hf, 4'h1, 16'h0234, 1'b1, 64, 1);
    frame(4'h0, 4'hf, 4'h0, 16'h0fff, 1'b1, 64, 0);
    frame(4'h0, 4'hf, 4'h0, 16'h0001, 1'b0, 12, 0);
    bus(1'b1, VTCF_A_CTRL, 32'h0000_0001);
    bus(1'b1, VTCF_A_PORT_BASE + 8'h03, 32'h0000_0002);
    frame(4'h0, 4'h8, 4'h0, 16'h0001, 1'b0, 64, 0);
    frame(4'h0, 4'h9, 4'h1, 16'h0001, 1'b0, 64, 1);
    bus(1'b1, VTCF_A_CTRL, 32'h0000_0000);
    frame(4'h0, 4'h8, 4'h8, 16'h0001, 1'b0, 64, 1);
    rdx(VTCF_A_FWD_CNT, 32'(nfw));
    rdx(VTCF_A_DROP_CNT, 32'(ndr));
    repeat (4) @(posedge clk);
    // A silent design must not pass: every note has to be used up
    `CHK("beats left", 32'd0, 32'(eq.size()))
    `CHK("infos left", 32'd0, 32'(iq.size()))
    `CHK("reads left", 32'd0, 32'(rq.size()))
    end_of_test();
  end
endmodule
`default_nettype wire
